// [src/spsl_pkg.sv]
package spsl_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STAT_OFS   = 8'h04;
   localparam logic [7:0] DATA_OFS   = 8'h08;
   localparam logic [7:0] IRQEN_OFS  = 8'h0c;
   localparam logic [7:0] IRQCLR_OFS = 8'h10;
   localparam logic [7:0] RXDAT_OFS  = 8'h14;

   // Control register fields
   localparam int CTRL_EN_BIT    = 0;
   localparam int CTRL_CLOCK_PHASE_SELECT_BIT  = 1;
   localparam int CTRL_WOR_BIT   = 2;
   localparam int CTRL_TXIE_BIT  = 3;
   localparam int CTRL_ERRIE_BIT = 4;
   localparam int CTRL_MFEN_BIT  = 5;
   localparam int CTRL_RATE_LSB  = 6;
   localparam logic [7:0] CTRL_RESET = 8'h02;

   // Status / interrupt fields
   localparam int ST_RXF  = 0;
   localparam int ST_TXE  = 1;
   localparam int ST_OVF  = 2;
   localparam int ST_MODE_FAULT_FLAG = 3;
   localparam logic [3:0] ST_RESET = 4'h2;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // First field is the most significant: order follows the bit positions
   typedef struct packed {
      logic [1:0] rate;
      logic       mode_fault_flag_en;
      logic       err_irq_en;
      logic       tx_irq_en;
      logic       wired_or;
      logic       clock_phase_select;
      logic       enable;
   } spsl_ctrl_t;

   typedef struct packed {
      logic       load;      // Shift register took the data register
      logic       byte_done; // Full byte received
      logic [7:0] rx_byte;
      logic       mode_fault_flag;
   } spsl_evt_t;

endpackage

// [src/spsl_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module spsl_sync #(
   parameter int W = 4
) (
   // Clock and reset
   input  wire logic         core_clk,
   input  wire logic         reset_n,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_q   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule // spsl_sync
`default_nettype wire

// [src/spsl_shifter.sv]
`timescale 1ns/1ns
`default_nettype none
module spsl_shifter (
   // Clock and reset
   input  wire logic               core_clk,
   input  wire logic               reset_n,
   // Control
   input  wire spsl_pkg::spsl_ctrl_t ctrl,
   input  wire logic [7:0]         tx_data,
   // Synchronised pins
   input  wire logic               sclk_s,
   input  wire logic               ss_n_s,
   input  wire logic               mosi_s,
   // Outputs
   output logic                    miso_bit,
   output logic                    miso_drive,
   output spsl_pkg::spsl_evt_t     evt
);
   typedef enum logic [1:0] {SH_IDLE, SH_RUN} spsl_sh_st_t;
   typedef struct packed {
      spsl_sh_st_t st;
      logic        sclk_prev;
      logic        ss_prev;
      logic [7:0]  sreg;
      logic [3:0]  edges;
      logic        miso;
      spsl_pkg::spsl_evt_t ev;
   } spsl_sh_t;

   spsl_sh_t s_q, s_d;
   logic     rise, fall, lead, trail, ss_fall;

   always_comb
   begin
      s_d       = s_q;
      s_d.ev    = '0;
      s_d.ev.rx_byte = s_q.ev.rx_byte;
      rise      = sclk_s & ~s_q.sclk_prev;
      fall      = ~sclk_s & s_q.sclk_prev;
      // Mode 0 idle-low clock: leading edge is rising
      lead      = rise & ~ss_n_s;
      trail     = fall & ~ss_n_s;
      ss_fall   = ~ss_n_s & s_q.ss_prev;
      s_d.sclk_prev = sclk_s;
      s_d.ss_prev   = ss_n_s;
      if (!ctrl.enable)
      begin
         s_d.st    = SH_IDLE;
         s_d.edges = '0;
      end
      else
      begin
         unique case (s_q.st)
            SH_IDLE:
            begin
               if (!ctrl.clock_phase_select && ss_fall)
               begin
                  s_d.st     = SH_RUN;
                  s_d.sreg   = tx_data;
                  s_d.miso   = tx_data[7];
                  s_d.edges  = '0;
                  s_d.ev.load = 1'b1;
               end
               else if (ctrl.clock_phase_select && lead)
               begin
                  s_d.st     = SH_RUN;
                  s_d.sreg   = tx_data;
                  s_d.miso   = tx_data[7];
                  s_d.edges  = '0;
                  s_d.ev.load = 1'b1;
               end
            end
            SH_RUN:
            begin
               // No reload from the data register while running
               // Phase 0 samples on the leading edge, phase 1 on trailing
               if (ctrl.clock_phase_select ? trail : lead)
               begin
                  s_d.sreg  = {s_q.sreg[6:0], mosi_s};
                  s_d.edges = s_q.edges + 4'h1;
               end
               if (ctrl.clock_phase_select ? lead : trail)
                  s_d.miso = s_q.sreg[7];
               if (trail && s_q.edges == (ctrl.clock_phase_select ? 4'h7 : 4'h8))
               begin
                  s_d.st = SH_IDLE;
                  s_d.ev.byte_done = 1'b1;
                  s_d.ev.rx_byte   = s_d.sreg;
               end
            end
            default: s_d.st = SH_IDLE;
         endcase
      end
      // Select high with a clock edge while running is flagged but leaves the state alone
      s_d.ev.mode_fault_flag = ctrl.mode_fault_flag_en & ss_n_s & (s_q.st == SH_RUN)
                    & (rise | fall);
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         s_q <= '{st: SH_IDLE, sclk_prev: 1'b0, ss_prev: 1'b1,
                  default: '0};
      else
         s_q <= s_d;
   end

   assign miso_bit   = s_q.miso;
   assign miso_drive = ~ss_n_s & ctrl.enable & (s_q.st == SH_RUN);
   assign evt        = s_q.ev;
endmodule // spsl_shifter
`default_nettype wire

// [src/spsl_top.sv]
// How it works
// - Both ends must use the same clock phase setting.
// - Reset sets the clock phase select bit.
// - Phase 0: select falling edge starts transfer, MSB driven at once.
// - Running transfer blocks reloading the shift register.
// - Late data writes stay in the data register.
// - Phase 1: first serial clock edge starts the transfer.
// - Select high: MISO released, serial clock ignored, may raise fault.
// - Select high does not change the transfer state machine.
// - Wired-OR bit makes MISO open-drain.
// - Enable bit gates operation; clearing it partially resets.
// - Transmit-empty interrupt only while its enable is set.
// - Transmit-empty set when a byte enters the shift register.
// - Flags: receive full, transmit empty, mode fault, overflow.
// - Control holds error irq enable, fault enable, rate select.
`timescale 1ns/1ns
`default_nettype none
module spsl_top (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial pins
   input  wire logic        serial_clock_pin,
   input  wire logic        ss_n,
   input  wire logic        mosi,
   output logic             miso_o,
   output logic             miso_oe,
   // Interrupt
   output logic             irq
);
   typedef struct packed {
      spsl_pkg::spsl_ctrl_t ctrl;
      logic [7:0]  tx_data;
      logic [7:0]  rx_data;
      logic [3:0]  status;
      logic [3:0]  irq_en;
      logic        ap_valid;
      logic        ap_write;
      logic [7:0]  ap_addr;
      logic [31:0] rdata;
   } spsl_st_t;

   spsl_st_t            r_q, r_d;
   logic [2:0]          pins_s;
   logic                miso_bit;
   logic                miso_drive;
   spsl_pkg::spsl_evt_t evt;
   logic [3:0]          set_v;
   logic [3:0]          clr_v;
   logic                st_wr;

   spsl_sync #(.W(3)) u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .async_in ({serial_clock_pin, ss_n, mosi}),
      .sync_out (pins_s)
   );

   spsl_shifter u_shift (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .ctrl       (r_q.ctrl),
      .tx_data    (r_q.tx_data),
      .sclk_s     (pins_s[2]),
      .ss_n_s     (pins_s[1]),
      .mosi_s     (pins_s[0]),
      .miso_bit   (miso_bit),
      .miso_drive (miso_drive),
      .evt        (evt)
   );

   always_comb
   begin
      r_d      = r_q;
      set_v    = '0;
      clr_v    = '0;
      st_wr    = r_q.ap_valid & r_q.ap_write;
      r_d.ap_valid = hsel & hready & (htrans == spsl_pkg::HTRANS_NONSEQ);
      r_d.ap_write = hwrite;
      r_d.ap_addr  = haddr;
      // Data phase writes
      if (st_wr)
      begin
         unique case (r_q.ap_addr)
            spsl_pkg::CTRL_OFS:   r_d.ctrl = hwdata[7:0];
            spsl_pkg::DATA_OFS:
            begin
               r_d.tx_data = hwdata[7:0];
               clr_v[spsl_pkg::ST_TXE] = 1'b1;
            end
            spsl_pkg::IRQEN_OFS:  r_d.irq_en = hwdata[3:0];
            spsl_pkg::IRQCLR_OFS: clr_v = clr_v | hwdata[3:0];
            default: ;
         endcase
      end
      // Reading received data clears receive full
      if (r_q.ap_valid && !r_q.ap_write &&
          r_q.ap_addr == spsl_pkg::RXDAT_OFS)
         clr_v[spsl_pkg::ST_RXF] = 1'b1;
      set_v[spsl_pkg::ST_TXE]  = evt.load;
      set_v[spsl_pkg::ST_RXF]  = evt.byte_done;
      set_v[spsl_pkg::ST_OVF]  = evt.byte_done &
                                 r_q.status[spsl_pkg::ST_RXF];
      set_v[spsl_pkg::ST_MODE_FAULT_FLAG] = evt.mode_fault_flag;
      if (evt.byte_done && !r_q.status[spsl_pkg::ST_RXF])
         r_d.rx_data = evt.rx_byte;
      // Set wins over clear
      r_d.status = (r_q.status & ~clr_v) | set_v;
      if (!r_q.ctrl.enable)
         r_d.status = spsl_pkg::ST_RESET;
      // Address-phase read data
      r_d.rdata = '0;
      unique case (haddr)
         spsl_pkg::CTRL_OFS:  r_d.rdata = {24'h0, r_d.ctrl};
         spsl_pkg::STAT_OFS:  r_d.rdata = {28'h0, r_d.status};
         spsl_pkg::DATA_OFS:  r_d.rdata = {24'h0, r_d.tx_data};
         spsl_pkg::IRQEN_OFS: r_d.rdata = {28'h0, r_d.irq_en};
         spsl_pkg::RXDAT_OFS: r_d.rdata = {24'h0, r_d.rx_data};
         default:             r_d.rdata = '0;
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         r_q         <= '0;
         r_q.ctrl    <= spsl_pkg::CTRL_RESET;
         r_q.status  <= spsl_pkg::ST_RESET;
      end
      else
         r_q <= r_d;
   end

   assign hrdata    = r_q.rdata;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // Open drain only drives low in wired-OR mode
   assign miso_o    = miso_bit;
   assign miso_oe   = miso_drive & (~r_q.ctrl.wired_or | ~miso_bit);
   // Transmit-empty gated by its own enable, errors by error enable
   assign irq = (r_q.status[spsl_pkg::ST_TXE] & r_q.ctrl.tx_irq_en &
                 r_q.irq_en[spsl_pkg::ST_TXE]) |
                (r_q.status[spsl_pkg::ST_RXF] &
                 r_q.irq_en[spsl_pkg::ST_RXF]) |
                (|(r_q.status[3:2] & r_q.irq_en[3:2]) &
                 r_q.ctrl.err_irq_en);

   a_clock_phase_select_reset: assert property (@(posedge core_clk)
      $rose(reset_n) |-> r_q.ctrl.clock_phase_select)
      else $error("phase bit not set after reset");
   a_txe_on_load: assert property (@(posedge core_clk) disable iff (!reset_n)
      evt.load && r_q.ctrl.enable |=> r_q.status[spsl_pkg::ST_TXE])
      else $error("transmit empty not set on load");
   a_irq_tx_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
      !r_q.ctrl.tx_irq_en && r_q.irq_en[1:0] == 2'b10 && !r_q.ctrl.err_irq_en
      |-> !irq)
      else $error("tx interrupt without enable");
   a_miso_release: assert property (@(posedge core_clk) disable iff (!reset_n)
      pins_s[1] |-> !miso_oe)
      else $error("miso driven while deselected");
   a_disable_idle: assert property (@(posedge core_clk) disable iff (!reset_n)
      !r_q.ctrl.enable |=> !miso_oe)
      else $error("active while disabled");
   a_ovf_set: assert property (@(posedge core_clk) disable iff (!reset_n)
      evt.byte_done && r_q.status[0] && r_q.ctrl.enable |=> r_q.status[2])
      else $error("overflow missed");
   a_wor_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
      r_q.ctrl.wired_or && miso_bit |-> !miso_oe)
      else $error("open drain drove high");
   a_late_write: assert property (@(posedge core_clk) disable iff (!reset_n)
      st_wr && r_q.ap_addr == spsl_pkg::DATA_OFS |=> r_q.tx_data ==
      $past(hwdata[7:0]))
      else $error("data write lost");
endmodule // spsl_top
`default_nettype wire

// [sim/spsl_master_model.sv]
`timescale 1ns/1ns
`default_nettype none
module spsl_master_model #(
   parameter int HALF = 32
) (
   // Serial pins
   output var logic sclk,
   output var logic ss_n,
   output var logic mosi,
   input  wire logic miso
);
   initial
   begin
      sclk = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
   end
   // One byte, clock idles low, phase passed in equals the slave's
   task automatic xfer(input logic clock_phase_select, input logic [7:0] tx,
                       output logic [7:0] rx);
      int i;
      #3;
      ss_n = 1'b0;
      mosi = clock_phase_select ? ~tx[7] : tx[7];
      #(2*HALF);
      for (i = 7; i >= 0; i--)
      begin
         sclk = 1'b1;
         if (clock_phase_select) mosi = tx[i];
         if (!clock_phase_select) rx[i] = miso;
         #HALF;
         sclk = 1'b0;
         if (clock_phase_select) rx[i] = miso;
         else if (i > 0) mosi = tx[i-1];
         #HALF;
      end
      ss_n = 1'b1;
      mosi = ~mosi;
      #(4*HALF);
   endtask
   // Select pulse with no clock, leaves a phase 0 slave mid-transfer
   task automatic select_pulse;
      #3;
      ss_n = 1'b0;
      #(4*HALF);
      ss_n = 1'b1;
      #(2*HALF);
   endtask
   // Clock edges while the slave is not selected
   task automatic idle_clocks(input int n);
      repeat (n)
      begin
         sclk = 1'b1;
         mosi = ~mosi;
         #HALF;
         sclk = 1'b0;
         #HALF;
      end
   endtask
endmodule // spsl_master_model
`default_nettype wire

// [sim/spsl_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) check_count++; if ((a) !== (b)) begin miscompares++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end
module spsl_top_tb;
   logic        core_clk, reset_n, hsel, hwrite, wor_mode, miso_last;
   logic [7:0]  haddr, rx;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, rd;
   wire  logic [31:0] hrdata;
   wire  logic  hreadyout, hresp, miso_o, miso_oe, irq, sclk, ss_n, mosi;
   wire  logic  miso_w;
   int          miscompares, check_count, oe_cnt, od_bad, n0;
   // Released line floats to the inverse of its last value, or pull-up
   assign miso_w = miso_oe ? miso_o : (wor_mode ? 1'b1 : ~miso_last);
   spsl_top dut (.core_clk(core_clk), .reset_n(reset_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .serial_clock_pin(sclk),
      .ss_n(ss_n), .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe),
      .irq(irq));
   spsl_master_model master (.sclk(sclk), .ss_n(ss_n), .mosi(mosi),
      .miso(miso_w));
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
   begin
      if (miso_oe) miso_last <= miso_o;
      if (miso_oe) oe_cnt <= oe_cnt + 1;
      if (wor_mode && miso_oe && miso_o) od_bad <= od_bad + 1;
   end
   task automatic close_out;
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      @(posedge core_clk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50) miscompares++;
         if (n > 50) close_out();
         @(posedge core_clk);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= spsl_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic irq_is(input logic e);
      int n;
      for (n = 0; n < 6 && irq !== e; n++) @(posedge core_clk);
      `CHK(irq, e)
   endtask
   task automatic t_reset;
      bus(0, spsl_pkg::CTRL_OFS, 0);
      `CHK(rd[7:0], spsl_pkg::CTRL_RESET)
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[3:0], spsl_pkg::ST_RESET)
      `CHK(hresp, 1'b0)
      bus(1, 8'h1c, 32'hffffffff);
      bus(0, 8'h1c, 0);
      `CHK(rd, 32'h0)
   endtask
   task automatic t_phase0;
      bus(1, spsl_pkg::CTRL_OFS, 32'h01);
      bus(1, spsl_pkg::DATA_OFS, 32'ha5);
      master.xfer(1'b0, 8'h3c, rx);
      `CHK(rx, 8'ha5)
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[3:0], 4'h3)
      bus(0, spsl_pkg::RXDAT_OFS, 0);
      `CHK(rd, 32'h3c)
   endtask
   task automatic t_late;
      bus(1, spsl_pkg::DATA_OFS, 32'h11);
      fork
         master.xfer(1'b0, 8'h77, rx);
         #200 bus(1, spsl_pkg::DATA_OFS, 32'h22);
      join
      `CHK(rx, 8'h11)
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[spsl_pkg::ST_TXE], 1'b0)
      master.xfer(1'b0, 8'h88, rx);
      `CHK(rx, 8'h22)
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[3:0], 4'h7)
      bus(1, spsl_pkg::IRQCLR_OFS, 32'h0f);
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[3:0], 4'h0)
   endtask
   task automatic t_phase1;
      bus(1, spsl_pkg::CTRL_OFS, 32'h03);
      bus(1, spsl_pkg::DATA_OFS, 32'hc3);
      n0 = oe_cnt;
      master.idle_clocks(8);
      `CHK(oe_cnt, n0)
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[spsl_pkg::ST_RXF], 1'b0)
      master.xfer(1'b1, 8'h96, rx);
      `CHK(rx, 8'hc3)
      bus(0, spsl_pkg::RXDAT_OFS, 0);
      `CHK(rd, 32'h96)
   endtask
   task automatic t_irq;
      bus(1, spsl_pkg::IRQEN_OFS, 32'h2);
      irq_is(1'b0);
      bus(1, spsl_pkg::CTRL_OFS, 32'h0b);
      irq_is(1'b1);
      bus(1, spsl_pkg::DATA_OFS, 32'h5a);
      irq_is(1'b0);
      master.xfer(1'b1, 8'h00, rx);
      irq_is(1'b1);
      bus(1, spsl_pkg::IRQCLR_OFS, 32'h2);
      irq_is(1'b0);
   endtask
   task automatic t_wor;
      bus(1, spsl_pkg::CTRL_OFS, 32'h05);
      wor_mode = 1'b1;
      bus(1, spsl_pkg::DATA_OFS, 32'he7);
      master.xfer(1'b0, 8'h18, rx);
      `CHK(rx, 8'he7)
      `CHK(od_bad, 0)
      wor_mode = 1'b0;
   endtask
   task automatic t_mode_fault_flag;
      bus(1, spsl_pkg::IRQEN_OFS, 32'h8);
      bus(1, spsl_pkg::CTRL_OFS, 32'h31);
      irq_is(1'b0);
      master.select_pulse();
      master.idle_clocks(1);
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[spsl_pkg::ST_MODE_FAULT_FLAG], 1'b1)
      irq_is(1'b1);
   endtask
   task automatic t_disable;
      bus(1, spsl_pkg::CTRL_OFS, 32'hf0);
      bus(0, spsl_pkg::CTRL_OFS, 0);
      `CHK(rd[7:0], 8'hf0)
      bus(0, spsl_pkg::STAT_OFS, 0);
      `CHK(rd[3:0], spsl_pkg::ST_RESET)
      n0 = oe_cnt;
      master.xfer(1'b0, 8'h42, rx);
      `CHK(oe_cnt, n0)
   endtask
   initial
   begin
      {reset_n, hsel, hwrite, wor_mode, miso_last, haddr, htrans} = '0;
      {hwdata, miscompares, check_count, oe_cnt, od_bad} = '0;
      hsize = 3'b010;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_reset();
      t_phase0();
      t_late();
      t_phase1();
      t_irq();
      t_wor();
      t_mode_fault_flag();
      t_disable();
      close_out();
   end
endmodule // spsl_top_tb
`default_nettype wire
